/* File: button_edge.sv */
/*
 * two-stage synchroniser plus edge detector for a vector of pushbuttons.
 * assumes the raw levels are steady for at least a few clocks per press.
 */
`timescale 1ns/1ps
module button_edge #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] held;

	// first stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (rst) begin
			meta <= '0;
			level <= '0;
			held <= '0;
		end else begin
			meta <= raw;
			level <= meta;
			held <= level;
		end
	end

	// one-cycle pulses on each edge of the settled level
	assign rise = level & ~held;
	assign fall = ~level & held;

endmodule

/* File: cpu_model.sv */
/*
 * processor side model: halt event pulses, state levels and the B valid flag.
 * assumes the bench asks for events and levels one clock ahead; one clock.
 */
`timescale 1ns/1ps
module cpu_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [4:0] fire,
	input wire logic ie_req,
	input wire logic cs_req,
	input wire logic load_b,
	input wire logic push_down_op,
	output logic [4:0] events,
	output logic interrupts_enabled,
	output logic control_state_flag,
	output logic b_valid_flag
);
	// events last one cycle, levels follow the request
	always_ff @(posedge clock) begin
		events <= rst ? 5'h0 : fire;
		interrupts_enabled <= ie_req & ~rst;
		control_state_flag <= cs_req & ~rst;
	end

	// operator loads B and marks it valid; push-down frees B again
	always_ff @(posedge clock) begin
		if (rst || push_down_op) begin
			b_valid_flag <= 1'b0;
		end else if (load_b) begin
			b_valid_flag <= 1'b1;
		end
	end
endmodule

/* File: maintenance_panel_control.sv */
/*
 * maintenance panel control: section clears and load sequence, register
 * clears, clock inhibit with stepping, processor stop qualifiers, local
 * isolation and register access operators.
 * assumes all switch and processor inputs are synchronous to clock, except
 * pushbuttons which are synchronised here; the processor acts on the pulses.
 */
`timescale 1ns/1ps

// How it works
// - split links: each wipe clears its section
// - linked: either wipe clears A, B, C
// - load press clears A,B; release loads
// - six register clears on selected processor
// - four multiplexor register clears, own buttons
// - display enable, processor and multiplexor scan select
// - gate clock of system or any unit
// - single press gives one gated pulse
// - train gives 500 ns of pulses, phase lamps
// - load medium select, card lamp lit
// - start restarts halted processor, clock enabled
// - conditional halt stops only with switch up
// - syllable stop halts, suppresses fetch
// - internal interrupt stop holds parameters
// - external stop only with interrupts enabled
// - stops except conditional halt qualified by control/normal state
// - parity stop halts on parity error
// - unit clear resets the processor
// - local isolates scan bus, enables readout
// - stack adjust runs push-down, clock enabled
// - read copies addressed register into A
// - write sets addressed register from A
// - control state: extended ops, no external interrupts
// - register access relies on B valid flag
module maintenance_panel_control (
	input wire logic clock,
	input wire logic rst,
	input wire logic section_a_wipe_button,
	input wire logic section_b_wipe_button,
	input wire logic sections_linked,
	input wire logic console_load_button,
	input wire logic panel_load_button,
	input wire logic card_load_select,
	input wire logic [panel_pkg::CPU_REG_COUNT-1:0] cpu_reg_clear_buttons,
	input wire logic [panel_pkg::MUX_REG_COUNT-1:0] mux_reg_clear_buttons,
	input wire logic display_enable,
	input wire logic cpu_select,
	input wire logic mux_select,
	input wire logic whole_system_clock_gate,
	input wire logic first_cpu_clock_gate,
	input wire logic second_cpu_clock_gate,
	input wire logic first_io_mux_clock_gate,
	input wire logic second_io_mux_clock_gate,
	input wire logic diag_clock_gate,
	input wire logic display_clock_gate,
	input wire logic single_pulse_button,
	input wire logic pulse_train_button,
	input wire logic start_button,
	input wire logic cond_halt_switch,
	input wire logic cond_halt_op,
	input wire logic syllable_stop_switch,
	input wire logic syllable_done,
	input wire logic inner_interrupt_stop,
	input wire logic internal_interrupt,
	input wire logic outer_interrupt_stop,
	input wire logic external_interrupt,
	input wire logic interrupts_enabled,
	input wire logic stop_in_control,
	input wire logic stop_in_normal,
	input wire logic control_state_flag,
	input wire logic parity_stop_switch,
	input wire logic parity_error,
	input wire logic unit_clear_button,
	input wire logic local_switch,
	input wire logic stack_adjust_button,
	input wire logic internal_reg_read_button,
	input wire logic internal_reg_write_button,
	input wire logic b_valid_flag,
	output logic [panel_pkg::SECTION_COUNT-1:0] section_clear,
	output logic load_command,
	output logic load_from_card,
	output logic card_load_lamp,
	output logic [panel_pkg::CPU_REG_COUNT-1:0] first_cpu_reg_clear,
	output logic [panel_pkg::CPU_REG_COUNT-1:0] second_cpu_reg_clear,
	output logic [panel_pkg::MUX_REG_COUNT-1:0] first_mux_reg_clear,
	output logic [panel_pkg::MUX_REG_COUNT-1:0] second_mux_reg_clear,
	output logic display_on,
	output logic scan_cpu_select,
	output logic scan_mux_select,
	output logic [panel_pkg::UNIT_COUNT-1:0] unit_clock_enable,
	output logic [2:0] phase_lamps,
	output logic cpu_halted,
	output logic param_hold,
	output logic fetch_suppress_level,
	output logic restart_pulse,
	output logic [1:0] cpu_unit_clear,
	output logic scan_bus_isolate,
	output logic readout_enable,
	output logic push_down_op,
	output logic read_reg_op,
	output logic write_reg_op,
	output logic extended_ops,
	output logic outer_interrupt_detect
);
	import panel_pkg::*;

	// ************************************************
	// button synchronisation
	// ************************************************
	logic [BTN_COUNT-1:0] raw_buttons, btn_level, btn_press, btn_fall;

	// choose target A (sel low) or B (sel high) of a pair
	function automatic logic [1:0] pick(input logic sel);
		pick = sel ? 2'h2 : 2'h1;
	endfunction

	assign raw_buttons = {mux_reg_clear_buttons, cpu_reg_clear_buttons, internal_reg_write_button,
		internal_reg_read_button, stack_adjust_button, unit_clear_button, start_button,
		pulse_train_button, single_pulse_button, panel_load_button, console_load_button,
		section_b_wipe_button, section_a_wipe_button};

	// every button becomes a clean one-cycle press pulse
	button_edge #(.WIDTH(BTN_COUNT)) buttons (
		.clock(clock),
		.rst(rst),
		.raw(raw_buttons),
		.level(btn_level),
		.rise(btn_press),
		.fall(btn_fall)
	);

	// ************************************************
	// general clear and load sequence
	// ************************************************
	logic wipe_a, wipe_b, load_press, load_release;
	logic [2:0] next_section_clear;

	assign wipe_a = btn_press[BTN_WIPE_A];
	assign wipe_b = btn_press[BTN_WIPE_B];
	assign load_press = btn_press[BTN_LOAD_CONSOLE] | btn_press[BTN_LOAD_PANEL];
	assign load_release = (btn_fall[BTN_LOAD_CONSOLE] & ~btn_level[BTN_LOAD_PANEL])
		| (btn_fall[BTN_LOAD_PANEL] & ~btn_level[BTN_LOAD_CONSOLE]);

	// section clear pattern from wipe buttons and load press
	always_comb begin
		next_section_clear = '0;
		if (sections_linked) begin
			if (wipe_a | wipe_b)
				next_section_clear = SECTIONS_ALL;
		end else begin
			if (wipe_a)
				next_section_clear = next_section_clear | SECTION_A;
			if (wipe_b)
				next_section_clear = next_section_clear | SECTION_B;
		end
		if (load_press)
			next_section_clear = next_section_clear | SECTIONS_AB;
	end

	always_ff @(posedge clock) begin
		if (rst)
			section_clear <= '0;
		else
			section_clear <= next_section_clear;
	end

	// load command on release, with the selected medium
	always_ff @(posedge clock) begin
		if (rst) begin
			load_command <= 1'b0;
			load_from_card <= 1'b0;
			card_load_lamp <= 1'b0;
		end else begin
			load_command <= load_release;
			if (load_release)
				load_from_card <= card_load_select;
			card_load_lamp <= card_load_select;
		end
	end

	// ************************************************
	// register clears and display selection
	// ************************************************
	// clears go only to the unit that the selector points at
	always_ff @(posedge clock) begin
		if (rst) begin
			first_cpu_reg_clear <= '0;
			second_cpu_reg_clear <= '0;
			first_mux_reg_clear <= '0;
			second_mux_reg_clear <= '0;
		end else begin
			first_cpu_reg_clear <= btn_press[BTN_REG_CLEAR +: CPU_REG_COUNT] & {CPU_REG_COUNT{~cpu_select}};
			second_cpu_reg_clear <= btn_press[BTN_REG_CLEAR +: CPU_REG_COUNT] & {CPU_REG_COUNT{cpu_select}};
			first_mux_reg_clear <= btn_press[BTN_MUX_CLEAR +: MUX_REG_COUNT] & {MUX_REG_COUNT{~mux_select}};
			second_mux_reg_clear <= btn_press[BTN_MUX_CLEAR +: MUX_REG_COUNT] & {MUX_REG_COUNT{mux_select}};
		end
	end

	// display enable and scan selectors
	always_ff @(posedge clock) begin
		if (rst) begin
			display_on <= 1'b0;
			scan_cpu_select <= 1'b0;
			scan_mux_select <= 1'b0;
		end else begin
			display_on <= display_enable;
			scan_cpu_select <= cpu_select;
			scan_mux_select <= mux_select;
		end
	end

	// ************************************************
	// clock inhibit, single pulse and pulse train
	// ************************************************
	logic [UNIT_COUNT-1:0] gate_switch;
	logic [TRAIN_WIDTH-1:0] train_left, train_done;
	logic train_start;

	assign gate_switch = {display_clock_gate, diag_clock_gate, second_io_mux_clock_gate,
		first_io_mux_clock_gate, second_cpu_clock_gate, first_cpu_clock_gate};
	assign train_start = btn_press[BTN_TRAIN] & (train_left == '0);
	assign train_done = TRAIN_WIDTH'(TRAIN_CYCLES) - train_left;

	// train counter; presses during a train are ignored
	always_ff @(posedge clock) begin
		if (rst)
			train_left <= '0;
		else if (train_start)
			train_left <= TRAIN_WIDTH'(TRAIN_CYCLES);
		else if (train_left != '0)
			train_left <= train_left - 1'b1;
	end

	// phase indicators follow the elapsed train time
	always_ff @(posedge clock) begin
		if (rst)
			phase_lamps <= '0;
		else if (train_left != '0)
			phase_lamps <= train_done[PHASE_LSB +: 3];
		else
			phase_lamps <= '0;
	end

	// per-unit enable: free running unless gated, then stepped
	for (genvar u = 0; u < UNIT_COUNT; u++) begin : gate
		always_ff @(posedge clock) begin
			if (rst)
				unit_clock_enable[u] <= 1'b1;
			else
				unit_clock_enable[u] <= ~(gate_switch[u] | whole_system_clock_gate)
					| (btn_press[BTN_SINGLE] & (train_left == '0))
					| (train_left != '0);
		end
	end

	// ************************************************
	// processor stop, start and clear
	// ************************************************
	logic cpu_clock_on, stop_qual, int_halt, halt_set, start_take;

	assign cpu_clock_on = ~whole_system_clock_gate & ~(cpu_select ? second_cpu_clock_gate : first_cpu_clock_gate);
	assign stop_qual = control_state_flag ? stop_in_control : stop_in_normal;
	assign int_halt = stop_qual & ((inner_interrupt_stop & internal_interrupt)
		| (outer_interrupt_stop & external_interrupt & interrupts_enabled & ~control_state_flag));
	assign halt_set = int_halt | (cond_halt_op & cond_halt_switch)
		| (stop_qual & ((syllable_stop_switch & syllable_done) | (parity_stop_switch & parity_error)));
	assign start_take = btn_press[BTN_START] & cpu_clock_on & cpu_halted;

	// halt flag: a new stop wins over start or unit clear
	always_ff @(posedge clock) begin
		if (rst) begin
			cpu_halted <= 1'b0;
			param_hold <= 1'b0;
		end else if (halt_set) begin
			cpu_halted <= 1'b1;
			param_hold <= int_halt | param_hold;
		end else if (start_take | btn_press[BTN_UNIT_CLEAR]) begin
			cpu_halted <= 1'b0;
			param_hold <= 1'b0;
		end
	end

	// restart, fetch suppress and unit clear
	always_ff @(posedge clock) begin
		if (rst) begin
			restart_pulse <= 1'b0;
			fetch_suppress_level <= 1'b0;
			cpu_unit_clear <= '0;
		end else begin
			restart_pulse <= start_take & ~halt_set;
			fetch_suppress_level <= syllable_stop_switch & stop_qual;
			cpu_unit_clear <= pick(cpu_select) & {2{btn_press[BTN_UNIT_CLEAR]}};
		end
	end

	// local isolation and control-state qualifiers
	always_ff @(posedge clock) begin
		if (rst) begin
			scan_bus_isolate <= 1'b0;
			readout_enable <= 1'b0;
			extended_ops <= 1'b0;
			outer_interrupt_detect <= 1'b1;
		end else begin
			scan_bus_isolate <= local_switch;
			readout_enable <= local_switch;
			extended_ops <= control_state_flag;
			outer_interrupt_detect <= ~control_state_flag;
		end
	end

	// ************************************************
	// stack adjust and register access operators
	// ************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			push_down_op <= 1'b0;
			read_reg_op <= 1'b0;
			write_reg_op <= 1'b0;
		end else begin
			push_down_op <= btn_press[BTN_ADJUST] & cpu_clock_on;
			read_reg_op <= btn_press[BTN_READ] & cpu_clock_on & b_valid_flag;
			write_reg_op <= btn_press[BTN_WRITE] & cpu_clock_on & b_valid_flag;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence load_held_s;
		load_press ##1 (~load_release)[*1];
	endsequence

	sequence gated_idle_s;
		first_cpu_clock_gate & ~btn_press[BTN_SINGLE] & (train_left == '0) & ~train_start;
	endsequence

	linked_clear_a: assert property (sections_linked & (wipe_a | wipe_b) |=> section_clear == SECTIONS_ALL)
		else $error("linked wipe did not clear all sections");
	split_clear_a: assert property (~sections_linked & wipe_a & ~wipe_b & ~load_press
		|=> section_clear == SECTION_A)
		else $error("split wipe A cleared wrong sections");
	load_seq_a: assert property (load_held_s |-> section_clear[1:0] == 2'h3 ##0 ~load_command)
		else $error("load press did not clear A and B");
	load_cmd_a: assert property (load_release |=> load_command ##1 ~load_command)
		else $error("load release gave no single load command");
	step_one_a: assert property (gated_idle_s ##1 (first_cpu_clock_gate & btn_press[BTN_SINGLE] & ~train_start
		& (train_left == '0)) ##1 gated_idle_s |-> unit_clock_enable[U_CPU0] ##1 ~unit_clock_enable[U_CPU0])
		else $error("single pulse not exactly one enable");
	train_run_a: assert property (train_start |=> train_left == TRAIN_WIDTH'(TRAIN_CYCLES)
		##1 unit_clock_enable[U_CPU0] [*8])
		else $error("pulse train did not run");
	cond_halt_a: assert property (cond_halt_op & cond_halt_switch |=> cpu_halted)
		else $error("conditional halt did not stop");
	outer_mask_a: assert property (~cpu_halted & control_state_flag & external_interrupt
		& ~internal_interrupt & ~cond_halt_op & ~syllable_done & ~parity_error |=> ~cpu_halted)
		else $error("external interrupt halted in control state");
	start_a: assert property (start_take & ~halt_set |=> restart_pulse & ~cpu_halted)
		else $error("start did not restart halted processor");
	read_gate_a: assert property (read_reg_op |-> $past(b_valid_flag) & $past(cpu_clock_on))
		else $error("read operator without valid B or clock");

endmodule

/* File: maintenance_panel_control_test.sv */
/*
 * self-checking bench for the maintenance panel control.
 * assumes cpu_model drives the processor side; pulses are checked from a queue.
 */
`timescale 1ns/1ps
module maintenance_panel_control_test;
	import panel_pkg::*;
	// ************************************************
	// stimulus and observed signals
	// ************************************************
	logic clock, rst, linked, card, ie, cs, ldb;
	logic [BTN_COUNT-1:0] btn;
	logic [6:0] gates;
	logic [4:0] fire;
	logic display_enable, cpu_select, mux_select, cond_halt_switch, syllable_stop_switch;
	logic inner_interrupt_stop, outer_interrupt_stop, stop_in_control, stop_in_normal;
	logic parity_stop_switch, local_switch, lamp_seen;
	wire logic [4:0] events;
	wire logic interrupts_enabled, control_state_flag, b_valid_flag;
	logic [2:0] section_clear, phase_lamps;
	logic load_command, load_from_card, card_load_lamp, display_on, scan_cpu_select, scan_mux_select;
	logic [5:0] first_cpu_reg_clear, second_cpu_reg_clear, unit_clock_enable;
	logic [3:0] first_mux_reg_clear, second_mux_reg_clear;
	logic cpu_halted, param_hold, fetch_suppress_level, restart_pulse, scan_bus_isolate, readout_enable;
	logic [1:0] cpu_unit_clear;
	logic push_down_op, read_reg_op, write_reg_op, extended_ops, outer_interrupt_detect;
	logic [29:0] pulses;
	logic [29:0] notes[$];
	int seed, failures, check_count, en_count;

	maintenance_panel_control i_dut (
		.clock, .rst, .section_a_wipe_button(btn[BTN_WIPE_A]), .section_b_wipe_button(btn[BTN_WIPE_B]),
		.sections_linked(linked), .console_load_button(btn[BTN_LOAD_CONSOLE]),
		.panel_load_button(btn[BTN_LOAD_PANEL]), .card_load_select(card),
		.cpu_reg_clear_buttons(btn[BTN_MUX_CLEAR-1:BTN_REG_CLEAR]),
		.mux_reg_clear_buttons(btn[BTN_COUNT-1:BTN_MUX_CLEAR]), .display_enable, .cpu_select, .mux_select,
		.whole_system_clock_gate(gates[6]), .first_cpu_clock_gate(gates[U_CPU0]),
		.second_cpu_clock_gate(gates[U_CPU1]), .first_io_mux_clock_gate(gates[U_MUX0]),
		.second_io_mux_clock_gate(gates[U_MUX1]), .diag_clock_gate(gates[U_DIAG]),
		.display_clock_gate(gates[U_DISP]), .single_pulse_button(btn[BTN_SINGLE]),
		.pulse_train_button(btn[BTN_TRAIN]), .start_button(btn[BTN_START]), .cond_halt_switch,
		.cond_halt_op(events[0]), .syllable_stop_switch, .syllable_done(events[1]), .inner_interrupt_stop,
		.internal_interrupt(events[2]), .outer_interrupt_stop, .external_interrupt(events[3]),
		.interrupts_enabled, .stop_in_control, .stop_in_normal, .control_state_flag, .parity_stop_switch,
		.parity_error(events[4]), .unit_clear_button(btn[BTN_UNIT_CLEAR]), .local_switch,
		.stack_adjust_button(btn[BTN_ADJUST]), .internal_reg_read_button(btn[BTN_READ]),
		.internal_reg_write_button(btn[BTN_WRITE]), .b_valid_flag, .section_clear, .load_command,
		.load_from_card, .card_load_lamp, .first_cpu_reg_clear, .second_cpu_reg_clear, .first_mux_reg_clear,
		.second_mux_reg_clear, .display_on, .scan_cpu_select, .scan_mux_select, .unit_clock_enable,
		.phase_lamps, .cpu_halted, .param_hold, .fetch_suppress_level, .restart_pulse, .cpu_unit_clear,
		.scan_bus_isolate, .readout_enable, .push_down_op, .read_reg_op, .write_reg_op, .extended_ops,
		.outer_interrupt_detect
	);

	cpu_model i_cpu (
		.clock, .rst, .fire, .ie_req(ie), .cs_req(cs), .load_b(ldb), .push_down_op, .events,
		.interrupts_enabled, .control_state_flag, .b_valid_flag
	);

	// all one-cycle pulses side by side
	assign pulses = {section_clear, load_command, first_cpu_reg_clear, second_cpu_reg_clear, first_mux_reg_clear,
		second_mux_reg_clear, restart_pulse, cpu_unit_clear, push_down_op, read_reg_op, write_reg_op};

	always #12.5 clock = ~clock;

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [29:0] e(input int pos, input logic [5:0] v);
		return {24'h0, v} << pos;
	endfunction

	task automatic check(input string name, input logic [29:0] seen, input logic [29:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// press and release a button, noting the pulses it should give
	task automatic press(input int i, input logic [29:0] exp, input logic [29:0] exp2);
		if (exp !== 30'h0) notes.push_back(exp);
		if (exp2 !== 30'h0) notes.push_back(exp2);
		btn[i] = 1'b1;
		repeat (4) @(negedge clock);
		btn[i] = 1'b0;
		repeat (5) @(negedge clock);
	endtask

	// raise one processor event and see whether it halts; restart if so
	task automatic ev(input int k, input logic halt);
		fire[k] = 1'b1;
		@(negedge clock);
		fire = 5'h0;
		repeat (3) @(negedge clock);
		check("halted", cpu_halted, halt);
		if (halt) begin
			check("hold", param_hold, k == 2 || k == 3);
			press(BTN_START, e(5, 1), 0);
			check("resumed", cpu_halted, 0);
		end
	endtask

	// ************************************************
	// pulse monitor, counters and watchdog
	// ************************************************
	always @(negedge clock) begin
		if (!rst && pulses !== 30'h0) begin
			check("pulses", pulses, notes.size() ? notes.pop_front() : 30'h0);
		end
		if (phase_lamps !== 3'h0) lamp_seen = 1'b1;
	end

	always @(negedge clock) begin
		if (unit_clock_enable[U_CPU0] === 1'b1) en_count++;
	end

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		report_and_stop();
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		{clock, linked, card, ie, cs, ldb, btn, gates, fire, lamp_seen} = '0;
		{display_enable, cpu_select, mux_select, cond_halt_switch, syllable_stop_switch} = '0;
		{inner_interrupt_stop, outer_interrupt_stop, stop_in_control, stop_in_normal} = '0;
		{parity_stop_switch, local_switch} = '0;
		seed = 74;
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		check("reset", {unit_clock_enable, outer_interrupt_detect}, 7'h7F);
		press(BTN_WIPE_A, e(27, SECTION_A), 0);
		press(BTN_WIPE_B, e(27, SECTION_B), 0);
		linked = 1'b1;
		press(BTN_WIPE_B, e(27, SECTIONS_ALL), 0);
		card = 1'b1;
		press(BTN_LOAD_PANEL, e(27, SECTIONS_AB), e(26, 1));
		check("card", {load_from_card, card_load_lamp}, 2'h3);
		card = 1'b0;
		press(BTN_LOAD_CONSOLE, e(27, SECTIONS_AB), e(26, 1));
		check("disk", {load_from_card, card_load_lamp}, 2'h0);
		for (int i = 0; i < CPU_REG_COUNT; i++) begin
			cpu_select = 1'($random(seed));
			@(negedge clock);
			press(BTN_REG_CLEAR + i, e(cpu_select ? 14 : 20, 6'h1 << i), 0);
		end
		for (int i = 0; i < MUX_REG_COUNT; i++) begin
			mux_select = 1'($random(seed));
			@(negedge clock);
			press(BTN_MUX_CLEAR + i, e(mux_select ? 6 : 10, 6'h1 << i), 0);
		end
		display_enable = 1'b1;
		cpu_select = 1'b1;
		mux_select = 1'b0;
		local_switch = 1'b1;
		repeat (2) @(negedge clock);
		check("scan", {display_on, scan_cpu_select, scan_mux_select}, 3'h6);
		check("local", {scan_bus_isolate, readout_enable}, 2'h3);
		press(BTN_UNIT_CLEAR, e(3, 2), 0);
		for (int i = 0; i < 7; i++) begin
			gates = 7'h1 << i;
			repeat (2) @(negedge clock);
			check("gate", unit_clock_enable, i == 6 ? 6'h0 : 6'(~(6'h1 << i)));
		end
		gates = 7'h1;
		cpu_select = 1'b0;
		repeat (2) @(negedge clock);
		en_count = 0;
		press(BTN_SINGLE, 0, 0);
		check("single", en_count, 1);
		en_count = 0;
		press(BTN_TRAIN, 0, 0);
		repeat (TRAIN_CYCLES) @(negedge clock);
		check("train", en_count, TRAIN_CYCLES);
		check("lamps", {lamp_seen, phase_lamps}, 4'h8);
		press(BTN_ADJUST, 0, 0);
		gates = 7'h0;
		press(BTN_READ, 0, 0);
		press(BTN_ADJUST, e(2, 1), 0);
		ldb = 1'b1;
		@(negedge clock);
		ldb = 1'b0;
		@(negedge clock);
		press(BTN_READ, e(1, 1), 0);
		press(BTN_WRITE, e(0, 1), 0);
		stop_in_normal = 1'b1;
		ev(0, 0);
		cond_halt_switch = 1'b1;
		ev(0, 1);
		press(BTN_START, 0, 0);
		syllable_stop_switch = 1'b1;
		repeat (2) @(negedge clock);
		check("fetch", fetch_suppress_level, 1);
		ev(1, 1);
		syllable_stop_switch = 1'b0;
		inner_interrupt_stop = 1'b1;
		stop_in_normal = 1'b0;
		ev(2, 0);
		stop_in_normal = 1'b1;
		ev(2, 1);
		outer_interrupt_stop = 1'b1;
		ev(3, 0);
		ie = 1'b1;
		ev(3, 1);
		cs = 1'b1;
		stop_in_control = 1'b1;
		repeat (3) @(negedge clock);
		check("control", {extended_ops, outer_interrupt_detect}, 2'h2);
		ev(3, 0);
		ev(2, 1);
		cs = 1'b0;
		parity_stop_switch = 1'b1;
		ev(4, 1);
		check("notes", notes.size(), 0);
		report_and_stop();
	end
endmodule

/* File: panel_pkg.sv */
/*
 * constants shared by the maintenance panel control logic: button slots,
 * clock unit slots, section slots and the pulse-train timing.
 * assumes a single 40 MHz system clock.
 */
package panel_pkg;

	// ************************************************
	// clock and pulse-train timing
	// ************************************************
	localparam int CLOCK_PERIOD_PS = 25000;
	localparam int TRAIN_TIME_NS = 500;
	localparam int TRAIN_CYCLES = (TRAIN_TIME_NS * 1000) / CLOCK_PERIOD_PS;
	localparam int TRAIN_WIDTH = 5;
	localparam int PHASE_LSB = 2;

	// ************************************************
	// pushbutton slots on the synchronised button vector
	// ************************************************
	localparam int BTN_WIPE_A = 0;
	localparam int BTN_WIPE_B = 1;
	localparam int BTN_LOAD_CONSOLE = 2;
	localparam int BTN_LOAD_PANEL = 3;
	localparam int BTN_SINGLE = 4;
	localparam int BTN_TRAIN = 5;
	localparam int BTN_START = 6;
	localparam int BTN_UNIT_CLEAR = 7;
	localparam int BTN_ADJUST = 8;
	localparam int BTN_READ = 9;
	localparam int BTN_WRITE = 10;
	localparam int BTN_REG_CLEAR = 11;
	localparam int CPU_REG_COUNT = 6;
	localparam int BTN_MUX_CLEAR = BTN_REG_CLEAR + CPU_REG_COUNT;
	localparam int MUX_REG_COUNT = 4;
	localparam int BTN_COUNT = BTN_MUX_CLEAR + MUX_REG_COUNT;

	// ************************************************
	// clock-gated units and cleared sections
	// ************************************************
	localparam int U_CPU0 = 0;
	localparam int U_CPU1 = 1;
	localparam int U_MUX0 = 2;
	localparam int U_MUX1 = 3;
	localparam int U_DIAG = 4;
	localparam int U_DISP = 5;
	localparam int UNIT_COUNT = 6;
	localparam int SECTION_COUNT = 3;
	localparam logic [2:0] SECTIONS_ALL = 3'h7;
	localparam logic [2:0] SECTIONS_AB = 3'h3;
	localparam logic [2:0] SECTION_A = 3'h1;
	localparam logic [2:0] SECTION_B = 3'h2;

	// ************************************************
	// register field carried by A in register access
	// ************************************************
	localparam int FIELD_TOP = 19;
	localparam int FIELD_LEN = 20;

endpackage
